// file: watchdog_with_locked_mode_register_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "wds_watchdog_regs.svh"
module watchdog_with_locked_mode_register_bench;
  logic clk, rst, bo, opt, hlt, stp, srec, pin_o, pin_oe, pu_en, crst, rc, pcyc, ex, wr;
  logic fwe, fz, fs, fv, act, win;
  logic [3:0] bank;
  logic [7:0] addr, wd, rnd;
  logic [2:0] exp_q[$];
  int failures = 0, n_tests = 0, n;
  // open-drain reset pin with internal pull-up
  wire pin = pin_oe ? pin_o : 1'b1;
  wds_watchdog u_dut (.CLK_SYS(clk), .SYS_RST(rst), .RC_OSC(rc), .BROWNOUT(bo),
    .OPT_WDT_AT_POR(opt), .RST_PIN_I(pin), .RST_PIN_O(pin_o), .RST_PIN_OE(pin_oe),
    .RST_PULLUP_EN(pu_en), .CORE_RST(crst), .PROC_CYC(pcyc), .WDT_EXEC(ex),
    .CPU_HALTED(hlt), .CPU_STOPPED(stp), .STOP_RECOVER(srec), .REG_BANK(bank),
    .REG_ADDR(addr), .REG_WDATA(wd), .REG_WR(wr), .FLAG_WE(fwe), .FLAG_Z(fz),
    .FLAG_S(fs), .FLAG_V(fv), .WDT_ACTIVE(act), .WIN_OPEN(win));
  wds_core_model u_core (.clk, .crst, .rc, .pcyc, .ex, .bank, .addr, .wd, .wr);
  always #12.5 clk = ~clk;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // returns a little after the edge so registered outputs have landed
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic run_wait();
    int i;
    i = 0;
    while (crst !== 1'b0 && i < 900)
    begin
      cyc(1);
      i++;
    end
    chk("released", crst, 0);
  endtask
  task automatic refresh();
    exp_q.push_back({`WDS_FLAG_Z, `WDS_FLAG_S, `WDS_FLAG_V});
    u_core.exec();
  endtask
  // t ticks of four clocks each, with slack for the sync stages
  task automatic expire(input int t);
    int i;
    cyc(t * 4 - 8);
    chk("early", crst, 0);
    i = 0;
    while (crst !== 1'b1 && i < 24)
    begin
      cyc(1);
      i++;
    end
    chk("expired", crst, 1);
    chk("pin low", pin, 0);
    cyc(2);
    chk("enable", act, opt);
    run_wait();
    $display("test done");
  endtask
  // flag monitor pairs each strobe with the oldest refresh
  always @(posedge clk)
  begin
    if (fwe === 1'b1)
      chk("flags", {fz, fs, fv}, exp_q.size() ? exp_q.pop_front() : 3'h7);
  end
  initial
  begin
    #2000000;
    failures++;
    print_verdict();
  end
  initial
  begin
    {clk, bo, opt, hlt, stp, srec} = '0;
    rst = 1'b1;
    rnd = 8'($urandom(32'h8adb6f70));
    cyc(20);
    chk("oe", pin_oe, 1);
    chk("pullup", pu_en, 0);
    @(posedge clk) rst <= 1'b0;
    run_wait();
    chk("idle", act, 0);
    chk("pullup run", pu_en, 1);
    // misdirected writes after the real one must leave the short tap
    u_core.put(4'hf, 8'h0f, {rnd[7:4], 4'hc});
    u_core.put(4'he, 8'h0f, 8'h03);
    u_core.put(4'hf, 8'h0e, 8'h03);
    refresh();
    expire(`WDS_TAP0 + 1);
    // refresh mid-count restarts the longer tap
    u_core.put(4'hf, 8'h0f, {rnd[3:0], 4'hd});
    refresh();
    cyc(3000);
    refresh();
    expire(`WDS_TAP1 + 1);
    n = 0;
    while (n < 60)
    begin
      cyc(1);
      if (pcyc === 1'b1) n++;
    end
    chk("window", win, 1);
    cyc(1);
    chk("closed", win, 0);
    u_core.put(4'hf, 8'h0f, 8'h0d);
    cyc(1200);
    chk("no refresh", crst, 0);
    @(posedge clk) srec <= 1'b1;
    @(posedge clk) srec <= 1'b0;
    cyc(1);
    chk("reopen", win, 1);
    refresh();
    expire(`WDS_TAP0 + 1);
    u_core.put(4'hf, 8'h0f, 8'h00);
    refresh();
    @(posedge clk) hlt <= 1'b1;
    cyc(1500);
    chk("halted", crst, 0);
    @(posedge clk) hlt <= 1'b0;
    expire(`WDS_TAP0);
    // stop and halt bits default to counting
    refresh();
    @(posedge clk) stp <= 1'b1;
    hlt <= 1'b1;
    expire(`WDS_TAP0 + 1);
    @(posedge clk) bo <= 1'b1;
    opt <= 1'b1;
    stp <= 1'b0;
    hlt <= 1'b0;
    cyc(20);
    chk("brown rst", crst, 1);
    chk("brown pin", pin_oe, 0);
    @(posedge clk) bo <= 1'b0;
    cyc(20);
    chk("por", crst, 1);
    run_wait();
    chk("opt enable", act, 1);
    // option on: expiry without any refresh, enable kept through reset
    expire(`WDS_TAP0 + 1);
    chk("flag queue", exp_q.size(), 0);
    print_verdict();
  end
endmodule // watchdog_with_locked_mode_register_bench
`default_nettype wire

// file: wds_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module wds_core_model (
  input wire logic clk,
  input wire logic crst,
  output logic rc,
  output logic pcyc,
  output logic ex,
  output logic [3:0] bank,
  output logic [7:0] addr,
  output logic [7:0] wd,
  output logic wr
);
  initial
  begin
    {rc, pcyc, ex, wr, bank, addr, wd} = '0;
  end
  // rc oscillator runs free, one tick every four clocks
  always #50 rc = ~rc;
  // core steps only out of reset, so the window counts real cycles
  always @(posedge clk) pcyc <= !crst && !pcyc;
  // refresh instruction, one cycle long
  task automatic exec();
    @(posedge clk) ex <= 1'b1;
    @(posedge clk) ex <= 1'b0;
  endtask
  // register write; data shows the inverse once released
  task automatic put(input logic [3:0] b, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) wr <= 1'b1;
    bank <= b;
    addr <= a;
    wd <= d;
    @(posedge clk) wr <= 1'b0;
    wd <= ~d;
  endtask
endmodule // wds_core_model
`default_nettype wire

// file: wds_pkg.sv
package wds_pkg;

  // reset sequencer states
  typedef enum logic [1:0] {
    WDS_BROWN,
    WDS_POR,
    WDS_RUN
  } wds_state_t;

  // timeout tap selection
  typedef logic [1:0] wds_tap_t;

endpackage

// file: wds_watchdog.sv
`timescale 1ns/1ps
`default_nettype none
`include "wds_watchdog_regs.svh"

// Functional notes
// R01 - one-shot counter resets core at terminal count
// R02 - inactive until first refresh instruction executes
// R03 - each refresh restarts count from zero
// R04 - counter clocked by on-chip rc oscillator
// R05 - refresh instruction updates zero, sign, overflow flags
// R06 - power-on reset timer also uses rc oscillator
// R07 - mode bits 0-1 select timeout tap
// R08 - mode bit 2 enables counting while halted
// R09 - mode bit 3 enables stop counting, default 1
// R10 - mode bits 4-7 reserved, no effect
// R11 - writes accepted only first 60 processor cycles
// R12 - later writes ignored until next reset/recovery
// R13 - mode register is write-only, no read path
// R14 - decoded at bank f, address 0fh
// R15 - stop-mode counting runs from rc oscillator
// R16 - option selects watchdog enabled at power-on
// R17 - brown-out holds reset, then full power-on sequence
// R18 - reset pin driven low, pull-up off, during por
// R19 - tap counts and bit 0-2 resets are constants
// R20 - watchdog reset clears enable unless option set
module wds_watchdog
  import wds_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic RC_OSC,
  input wire logic BROWNOUT,
  input wire logic OPT_WDT_AT_POR,
  input wire logic RST_PIN_I,
  output logic RST_PIN_O,
  output logic RST_PIN_OE,
  output logic RST_PULLUP_EN,
  output logic CORE_RST,
  input wire logic PROC_CYC,
  input wire logic WDT_EXEC,
  input wire logic CPU_HALTED,
  input wire logic CPU_STOPPED,
  input wire logic STOP_RECOVER,
  input wire logic [3:0] REG_BANK,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  output logic FLAG_WE,
  output logic FLAG_Z,
  output logic FLAG_S,
  output logic FLAG_V,
  output logic WDT_ACTIVE,
  output logic WIN_OPEN
);

  import wds_pkg::*;

  logic rc_s1_q;
  logic rc_s2_q;
  logic rc_s3_q;
  logic bo_s1_q;
  logic bo_s2_q;
  logic opt_s1_q;
  logic opt_s2_q;
  logic pin_s1_q;
  logic pin_s2_q;
  logic rc_tick;
  wds_state_t state_q;
  logic [7:0] por_cnt_q;
  logic in_reset;
  logic [3:0] mode_q;
  logic wr_hit;
  logic [5:0] win_cnt_q;
  logic win_open_q;
  logic active_q;
  logic [15:0] wd_cnt_q;
  logic [15:0] tap_val;
  logic cnt_en;
  logic expire;
  logic core_rst_q;
  logic pin_oe_q;
  logic pullup_q;
  logic flag_we_q;
  logic flag_z_q;
  logic flag_s_q;
  logic flag_v_q;

  // pins are asynchronous to CLK_SYS, two flops before any use
  // rc pin: third flop only feeds the edge detect, never the first
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      rc_s1_q <= 1'b0;
      rc_s2_q <= 1'b0;
      rc_s3_q <= 1'b0;
    end
    else
    begin
      rc_s1_q <= RC_OSC; // R04
      rc_s2_q <= rc_s1_q;
      rc_s3_q <= rc_s2_q;
    end
  end

  // brown-out level; pulses shorter than a clock may go unseen
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      bo_s1_q <= 1'b0;
      bo_s2_q <= 1'b0;
    end
    else
    begin
      bo_s1_q <= BROWNOUT;
      bo_s2_q <= bo_s1_q;
    end
  end

  // otp option is static, synced only to stay in one clock domain
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      opt_s1_q <= 1'b0;
      opt_s2_q <= 1'b0;
    end
    else
    begin
      opt_s1_q <= OPT_WDT_AT_POR;
      opt_s2_q <= opt_s1_q;
    end
  end

  // reset pin echo; resets high so no false low follows reset
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      pin_s1_q <= 1'b1;
      pin_s2_q <= 1'b1;
    end
    else
    begin
      pin_s1_q <= RST_PIN_I;
      pin_s2_q <= pin_s1_q;
    end
  end

  // one enable per rc period; the crystal may stop, this does not
  assign rc_tick = rc_s2_q & ~rc_s3_q; // R04

  // reset sequencer: brown-out hold, por timing, run
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      state_q <= WDS_POR;
      por_cnt_q <= 8'h00;
    end
    else
    begin
      case (state_q)
        WDS_BROWN:
        begin
          por_cnt_q <= 8'h00;
          if (!bo_s2_q)
            state_q <= WDS_POR; // R17
        end
        WDS_POR:
        begin
          if (bo_s2_q)
            state_q <= WDS_BROWN; // R17
          else if (rc_tick)
          begin
            // por duration counted in rc periods
            if (por_cnt_q == `WDS_POR_TICKS - 8'h01) // R06
            begin
              state_q <= WDS_RUN;
              por_cnt_q <= 8'h00;
            end
            else
              por_cnt_q <= por_cnt_q + 8'h01;
          end
        end
        WDS_RUN:
        begin
          por_cnt_q <= 8'h00;
          if (bo_s2_q)
            state_q <= WDS_BROWN; // R17
          else if (expire)
            state_q <= WDS_POR; // R01
        end
        default:
        begin
          state_q <= WDS_POR;
          por_cnt_q <= 8'h00;
        end
      endcase
    end
  end

  // the external pin also resets the core, but restarts no sequence
  assign in_reset = (state_q != WDS_RUN) | ~pin_s2_q;

  // core reset and pin drive; pin is not driven under brown-out
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      core_rst_q <= 1'b1;
      pin_oe_q <= 1'b1;
      pullup_q <= 1'b0;
    end
    else
    begin
      core_rst_q <= in_reset; // R17
      pin_oe_q <= (state_q == WDS_POR); // R18
      pullup_q <= (state_q != WDS_POR); // R18
    end
  end

  assign CORE_RST = core_rst_q;
  assign RST_PIN_OE = pin_oe_q;
  assign RST_PULLUP_EN = pullup_q;

  // open-drain style: only ever drives low
  always_ff @(posedge CLK_SYS)
  begin
    RST_PIN_O <= 1'b0; // R18
  end

  // write window, reopened by every reset and stop recovery
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST || in_reset || STOP_RECOVER)
    begin
      win_cnt_q <= 6'h00;
      win_open_q <= 1'b1;
    end
    else if (win_open_q && PROC_CYC)
    begin
      if (win_cnt_q == `WDS_WIN_CYCLES - 6'h01) // R11
        win_open_q <= 1'b0; // R12
      else
        win_cnt_q <= win_cnt_q + 6'h01;
    end
  end

  assign WIN_OPEN = win_open_q;

  // decode: bank f, offset 0fh, write strobe only
  always_comb
  begin
    if (REG_WR && REG_BANK == `WDS_MODE_BANK && REG_ADDR == `WDS_MODE_OFFSET) // R14
      wr_hit = 1'b1;
    else
      wr_hit = 1'b0;
  end

  // mode register; reserved upper bits are never stored
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST || in_reset)
    begin
      mode_q[`WDS_SEL_MSB:`WDS_SEL_LSB] <= `WDS_RST_SEL; // R19
      mode_q[`WDS_HALT_BIT] <= `WDS_RST_HALT; // R19
      mode_q[`WDS_STOP_BIT] <= `WDS_RST_STOP; // R09
    end
    else if (wr_hit && win_open_q) // R11
      mode_q <= REG_WDATA[3:0]; // R10
    // no read path exists, contents never reach the bus
  end // R13

  // tap select sets the terminal count
  always_comb
  begin
    case (wds_tap_t'(mode_q[`WDS_SEL_MSB:`WDS_SEL_LSB]))
      2'h0: tap_val = `WDS_TAP0; // R07
      2'h1: tap_val = `WDS_TAP1;
      2'h2: tap_val = `WDS_TAP2;
      default: tap_val = `WDS_TAP3;
    endcase
  end

  // enable latch; reset clears it unless the option forces it on
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
      active_q <= 1'b0;
    else if (in_reset)
      active_q <= opt_s2_q; // R16 R20
    else if (WDT_EXEC)
      active_q <= 1'b1; // R02
  end

  assign WDT_ACTIVE = active_q;

  // counting gated by halt and stop bits; stop relies on rc ticks
  assign cnt_en = active_q & rc_tick
    & (~CPU_HALTED | mode_q[`WDS_HALT_BIT]) // R08
    & (~CPU_STOPPED | mode_q[`WDS_STOP_BIT]); // R09 R15
  assign expire = cnt_en & (wd_cnt_q == tap_val); // R01

  // refresh wins over a counting tick in the same cycle, but not over the tick that expires
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST || in_reset)
      wd_cnt_q <= 16'h0000;
    else if (WDT_EXEC)
      wd_cnt_q <= 16'h0000; // R03
    else if (cnt_en && !expire)
      wd_cnt_q <= wd_cnt_q + 16'h0001; // R01
  end

  // condition flags handed back to the core on each refresh
  always_ff @(posedge CLK_SYS)
  begin
    if (SYS_RST)
    begin
      flag_we_q <= 1'b0;
      flag_z_q <= 1'b0;
      flag_s_q <= 1'b0;
      flag_v_q <= 1'b0;
    end
    else
    begin
      flag_we_q <= WDT_EXEC & ~in_reset; // R05
      if (WDT_EXEC)
      begin
        flag_z_q <= `WDS_FLAG_Z; // R05
        flag_s_q <= `WDS_FLAG_S;
        flag_v_q <= `WDS_FLAG_V;
      end
    end
  end

  assign FLAG_WE = flag_we_q;
  assign FLAG_Z = flag_z_q;
  assign FLAG_S = flag_s_q;
  assign FLAG_V = flag_v_q;

endmodule // wds_watchdog

`default_nettype wire

// file: wds_watchdog_props.sv
`timescale 1ns/1ps
`default_nettype none
module wds_watchdog_props (
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  input wire logic BROWNOUT,
  input wire logic WDT_EXEC,
  input wire logic STOP_RECOVER,
  input wire logic RST_PIN_O,
  input wire logic RST_PIN_OE,
  input wire logic RST_PULLUP_EN,
  input wire logic CORE_RST,
  input wire logic FLAG_WE,
  input wire logic FLAG_Z,
  input wire logic FLAG_S,
  input wire logic FLAG_V,
  input wire logic WDT_ACTIVE,
  input wire logic WIN_OPEN
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  // refresh answers with a flag strobe unless reset refuses it
  flag_answer_a: assert property (WDT_EXEC |=> FLAG_WE != CORE_RST)
    else $error("no flag strobe");
  flag_cause_a: assert property (FLAG_WE |-> $past(WDT_EXEC)) else $error("stray strobe");
  flag_value_a: assert property (FLAG_WE |-> !(FLAG_Z | FLAG_S | FLAG_V)) else $error("flags");
  enable_set_a: assert property (WDT_EXEC |=> WDT_ACTIVE || CORE_RST) else $error("not enabled");
  // pin driven low only with pull-up off and core held
  pin_drive_a: assert property (RST_PIN_OE |-> !RST_PIN_O && !RST_PULLUP_EN && CORE_RST)
    else $error("pin drive");
  brown_hold_a: assert property (BROWNOUT [*5] |=> CORE_RST && !RST_PIN_OE)
    else $error("brown-out hold");
  // window reopens only through a reset or a stop recovery
  win_lock_a: assert property ($rose(WIN_OPEN) |-> CORE_RST || $past(CORE_RST)
    || $past(STOP_RECOVER)) else $error("window reopened");
  enable_keep_a: assert property ($fell(WDT_ACTIVE) |-> ##[0:1] CORE_RST)
    else $error("enable lost");
  cover property (WDT_EXEC);
  cover property ($rose(RST_PIN_OE));
  cover property ($fell(WIN_OPEN));
endmodule // wds_watchdog_props
bind wds_watchdog wds_watchdog_props u_props (.CLK_SYS, .SYS_RST, .BROWNOUT, .WDT_EXEC,
  .STOP_RECOVER, .RST_PIN_O, .RST_PIN_OE, .RST_PULLUP_EN, .CORE_RST, .FLAG_WE, .FLAG_Z,
  .FLAG_S, .FLAG_V, .WDT_ACTIVE, .WIN_OPEN);
`default_nettype wire

// file: wds_watchdog_regs.svh
`ifndef WDS_WATCHDOG_REGS_SVH
`define WDS_WATCHDOG_REGS_SVH

// mode register location in the expanded register group
`define WDS_MODE_BANK 4'hf
`define WDS_MODE_OFFSET 8'h0f

// mode register field positions
`define WDS_SEL_LSB 0
`define WDS_SEL_MSB 1
`define WDS_HALT_BIT 2
`define WDS_STOP_BIT 3

// mode register reset values (stop bit documented as 1)
`define WDS_RST_SEL 2'h0
`define WDS_RST_HALT 1'b1
`define WDS_RST_STOP 1'b1

// terminal counts for the four taps, in rc oscillator periods
`define WDS_TAP0 16'h00ff
`define WDS_TAP1 16'h03ff
`define WDS_TAP2 16'h0fff
`define WDS_TAP3 16'hffff

// write window length in processor cycles
`define WDS_WIN_CYCLES 6'h3c

// power-on reset duration in rc oscillator periods
`define WDS_POR_TICKS 8'h40

// condition flag values driven when the refresh executes
`define WDS_FLAG_Z 1'b0
`define WDS_FLAG_S 1'b0
`define WDS_FLAG_V 1'b0

`endif
